// >>> logic/seo_defines.svh
`ifndef SEO_DEFINES_SVH
`define SEO_DEFINES_SVH

`define SEO_CLK_HZ 100000000
`define SEO_CLK_MHZ 100

`define SEO_OFF_CTRL 12'h000
`define SEO_OFF_STATUS 12'h004
`define SEO_OFF_VALUE 12'h008
`define SEO_CTRL_RST 20'h00000

`define SEO_CLAMP_HI_BASE 96
`define SEO_CLAMP_HI_SAT 70
`define SEO_CLAMP_LO_BASE 4
`define SEO_CLAMP_LO_SAT 30
`define SEO_CLAMP_LAST_CODE 26
`define SEO_FULL_SCALE 4095
`define SEO_PCT_FULL 100

`define SEO_TICK0_NS 3000
`define SEO_TICK1_NS 5000
`define SEO_TICK2_NS 2500
`define SEO_TICK3_NS 2000
`define SEO_TICK4_NS 1500
`define SEO_TICK5_NS 1000
`define SEO_TICK6_NS 750
`define SEO_TICK7_NS 500

`define SEO_PWM0_HZ 1000
`define SEO_PWM1_HZ 250
`define SEO_PWM2_HZ 500
`define SEO_PWM3_HZ 1600
`define SEO_PWM4_HZ 2667
`define SEO_PWM5_HZ 4000
`define SEO_PWM6_HZ 8000
`define SEO_PWM7_HZ 16000

`define SEO_PWM_RES_SLOW 12
`define SEO_PWM_RES5 11
`define SEO_PWM_RES6 10
`define SEO_PWM_RES7 9

`define SEO_NIB_LOW_TICKS 5
`define SEO_SYNC_TICKS 56
`define SEO_NIB_BASE_TICKS 12
`define SEO_NIB_MAX_TICKS 27
`define SEO_PAUSE_MIN_TICKS 12
`define SEO_CRC_SEED 4'h5
`define SEO_CRC_POLY 4'hd

`endif

// >>> logic/seo_pkg.sv
package seo_pkg;

  typedef struct packed {
    logic       diagEn;
    logic       crcCoversStatusNibble;
    logic [1:0] dataCfg;
    logic [4:0] clampLo;
    logic [4:0] clampHi;
    logic [2:0] rate;
    logic       analogSel;
    logic [1:0] outMode;
  } seo_ctrl_s;

  typedef struct packed {
    logic [11:0] pressure;
    logic [7:0]  diag;
    logic [11:0] intTemp;
  } seo_sense_s;

  typedef enum logic [1:0] {
    SS_IDLE,
    SS_SYNC,
    SS_NIB,
    SS_PAUSE
  } seo_sent_e;

endpackage

// >>> logic/seo_pwm.sv
`include "seo_defines.svh"

module seo_pwm
  import seo_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        enable,
  input  wire logic [31:0] periodCycles,
  input  wire logic [31:0] highCycles,
  output logic             pwmOut
);

  logic [31:0] cnt;
  logic [31:0] highHold;
  logic [31:0] periodHold;

  // Period counter
  always_ff @(posedge sys_clk) begin
    if (rst || !enable) begin
      cnt <= 32'h0;
    end else if (cnt >= periodHold - 32'h1) begin
      cnt <= 32'h0;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end

  // Settings latched per period to avoid glitches
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      highHold   <= 32'h0;
      periodHold <= 32'h1;
    end else if (!enable || cnt >= periodHold - 32'h1) begin
      highHold   <= highCycles;
      periodHold <= (periodCycles == 32'h0) ? 32'h1 : periodCycles;
    end
  end

  // Output level
  always_ff @(posedge sys_clk) begin
    if (rst || !enable) begin
      pwmOut <= 1'b0;
    end else begin
      pwmOut <= (cnt < highHold);
    end
  end

endmodule

// >>> logic/seo_top.sv
// The implementer's own choices: register access over APB and the register addresses.
`include "seo_defines.svh"

// Operation
// - High clamp code 0..26 gives 96 minus code percent, 27..31 give 70.
// - Low clamp code 0..26 gives 4 plus code percent, 27..31 give 30.
// - Normal values are limited between the clamps; outside means malfunction.
// - With diagnostics enabled, a fault puts the output to high impedance, except in PWM mode 0, which drives zero duty instead.
// - Analog mode drives a level proportional to the compensated signal.
// - PWM mode uses constant carrier; high fraction follows signal amplitude.
// - Rate code selects PWM carrier 1000,250,500,1600,2667,4000,8000,16000 Hz.
// - PWM duty cycle is clamped like the analog level, then cut to 11, 10 and 9 bits at rate codes 5, 6 and 7.
// - SENT sends the signal as 12-bit unsigned 0..4095 value.
// - Mode 2 sends SENT without pause pulse, mode 3 with pause.
// - Each SENT pulse starts with a low interval of exactly 5 ticks.
// - Nibble length is low plus high interval, counted in whole ticks.
// - Frame order: sync, status nibble, data nibbles, CRC, optional pause.
// - Rate code selects tick 3,5,2.5,2,1.5,1,0.75,0.5 microseconds.
// - Sync pulse lasts 56 ticks, falling edge to falling edge.
// - Pause pads every frame to 56+(N+2)*27+12 ticks, at least 12.
// - Data code picks pressure, plus diagnostics or temperature, MSB first.
module seo_top
  import seo_pkg::*;
#(
  parameter int unsigned PWM_CLK_HZ = `SEO_CLK_HZ
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire seo_sense_s  sense,
  input  wire logic        faultDet,
  output logic [11:0]      analogLevel,
  output logic             analogEn,
  output logic             sigOut,
  output logic             sigOutEn
);

  seo_ctrl_s   ctrl;
  seo_sent_e   state;
  logic [8:0]  tickCnt;
  logic [8:0]  tickIdx;
  logic [8:0]  pulseLen;
  logic [8:0]  frameTicks;
  logic [2:0]  nibIdx;
  logic [3:0]  frameNib [0:7];
  logic        errLatch;
  logic [3:0]  lastCrc;
  logic [15:0] frameCount;
  logic [11:0] clampedValue;
  logic        pwmWave;
  logic [31:0] pwmHigh;

  logic        fault;
  logic        sentOn;
  logic        pwmOn;
  logic        tickStrobe;
  logic        pulseEnd;
  logic [2:0]  dataCount;
  logic [11:0] clampHiCode;
  logic [11:0] clampLoCode;
  logic [11:0] pwmDuty;
  logic [31:0] pwmPeriod;
  logic [3:0]  dataNib [0:5];
  logic [3:0]  next_crc;
  logic [8:0]  frameTotal;
  logic [8:0]  next_pauseLen;
  logic        apbAccess;
  logic        apbMapped;

  function automatic logic [6:0] clampHiPct(input logic [4:0] code);
    if (code > 5'(`SEO_CLAMP_LAST_CODE)) begin
      return 7'(`SEO_CLAMP_HI_SAT);
    end
    return 7'(`SEO_CLAMP_HI_BASE) - {2'b00, code};
  endfunction

  function automatic logic [6:0] clampLoPct(input logic [4:0] code);
    if (code > 5'(`SEO_CLAMP_LAST_CODE)) begin
      return 7'(`SEO_CLAMP_LO_SAT);
    end
    return 7'(`SEO_CLAMP_LO_BASE) + {2'b00, code};
  endfunction

  function automatic logic [11:0] pctToCode(input logic [6:0] pct);
    logic [31:0] prod;
    prod = 32'(pct) * 32'(`SEO_FULL_SCALE) / 32'(`SEO_PCT_FULL);
    return prod[11:0];
  endfunction

  function automatic logic [8:0] tickCycles(input logic [2:0] rate);
    logic [31:0] ns;
    case (rate)
      3'h0:    ns = `SEO_TICK0_NS;
      3'h1:    ns = `SEO_TICK1_NS;
      3'h2:    ns = `SEO_TICK2_NS;
      3'h3:    ns = `SEO_TICK3_NS;
      3'h4:    ns = `SEO_TICK4_NS;
      3'h5:    ns = `SEO_TICK5_NS;
      3'h6:    ns = `SEO_TICK6_NS;
      default: ns = `SEO_TICK7_NS;
    endcase
    ns = ns * `SEO_CLK_MHZ / 1000;
    return ns[8:0];
  endfunction

  function automatic logic [31:0] pwmHz(input logic [2:0] rate);
    case (rate)
      3'h0:    return `SEO_PWM0_HZ;
      3'h1:    return `SEO_PWM1_HZ;
      3'h2:    return `SEO_PWM2_HZ;
      3'h3:    return `SEO_PWM3_HZ;
      3'h4:    return `SEO_PWM4_HZ;
      3'h5:    return `SEO_PWM5_HZ;
      3'h6:    return `SEO_PWM6_HZ;
      default: return `SEO_PWM7_HZ;
    endcase
  endfunction

  function automatic logic [3:0] pwmRes(input logic [2:0] rate);
    case (rate)
      3'h5:    return 4'(`SEO_PWM_RES5);
      3'h6:    return 4'(`SEO_PWM_RES6);
      3'h7:    return 4'(`SEO_PWM_RES7);
      default: return 4'(`SEO_PWM_RES_SLOW);
    endcase
  endfunction

  function automatic logic [3:0] crcStep(input logic [3:0] c, input logic [3:0] nib);
    logic [3:0] r;
    logic       msb;
    r = c;
    for (int i = 3; i >= 0; i--) begin
      msb = r[3];
      r = {r[2:0], nib[i]};
      if (msb) begin
        r = r ^ `SEO_CRC_POLY;
      end
    end
    return r;
  endfunction

  assign fault  = faultDet && ctrl.diagEn;
  assign sentOn = !ctrl.analogSel && ctrl.outMode[1];
  assign pwmOn  = !ctrl.analogSel && !ctrl.outMode[1];

  assign clampHiCode = pctToCode(clampHiPct(ctrl.clampHi));
  assign clampLoCode = pctToCode(clampLoPct(ctrl.clampLo));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clampedValue <= 12'h000;
    end else if (sense.pressure > clampHiCode) begin
      clampedValue <= clampHiCode;
    end else if (sense.pressure < clampLoCode) begin
      clampedValue <= clampLoCode;
    end else begin
      clampedValue <= sense.pressure;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      analogLevel <= 12'h000;
      analogEn    <= 1'b0;
    end else begin
      analogLevel <= clampedValue;
      analogEn    <= ctrl.analogSel && !fault;
    end
  end

  assign pwmPeriod = 32'(PWM_CLK_HZ) / pwmHz(ctrl.rate);

  always_comb begin
    pwmDuty = clampedValue & (12'hfff << (4'(`SEO_PWM_RES_SLOW) - pwmRes(ctrl.rate)));
    // Level reporting: fault drives duty below low clamp
    if (fault) begin
      pwmDuty = 12'h000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwmHigh <= 32'h0;
    end else begin
      pwmHigh <= (pwmPeriod * 32'(pwmDuty)) >> 12;
    end
  end

  seo_pwm u_pwm (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .enable       (pwmOn),
    .periodCycles (pwmPeriod),
    .highCycles   (pwmHigh),
    .pwmOut       (pwmWave)
  );

  always_comb begin
    dataNib[0] = sense.pressure[11:8];
    dataNib[1] = sense.pressure[7:4];
    dataNib[2] = sense.pressure[3:0];
    dataNib[3] = (ctrl.dataCfg == 2'h1) ? sense.diag[7:4] : sense.intTemp[11:8];
    dataNib[4] = (ctrl.dataCfg == 2'h1) ? sense.diag[3:0] : sense.intTemp[7:4];
    dataNib[5] = sense.intTemp[3:0];
    case (ctrl.dataCfg)
      2'h0:    dataCount = 3'h3;
      2'h1:    dataCount = 3'h5;
      default: dataCount = 3'h6;
    endcase
  end

  always_comb begin
    next_crc = `SEO_CRC_SEED;
    if (ctrl.crcCoversStatusNibble) begin
      next_crc = crcStep(next_crc, frameNib[0]);
    end
    for (int i = 0; i < 6; i++) begin
      if (3'(i) < dataCount) begin
        next_crc = crcStep(next_crc, dataNib[i]);
      end
    end
    next_crc = crcStep(next_crc, 4'h0);
  end

  assign frameTotal    = 9'(`SEO_SYNC_TICKS) + 9'(`SEO_PAUSE_MIN_TICKS)
                       + 9'({6'h0, dataCount} + 9'h2) * 9'(`SEO_NIB_MAX_TICKS);
  assign next_pauseLen = frameTotal - frameTicks - 9'h1;

  assign tickStrobe = (state != SS_IDLE) && (tickCnt == tickCycles(ctrl.rate) - 9'h1);
  assign pulseEnd   = tickStrobe && (tickIdx == pulseLen - 9'h1);

  always_ff @(posedge sys_clk) begin
    if (rst || state == SS_IDLE || tickStrobe) begin
      tickCnt <= 9'h0;
    end else begin
      tickCnt <= tickCnt + 9'h1;
    end
  end

  // count whole ticks of each pulse
  always_ff @(posedge sys_clk) begin
    if (rst || state == SS_IDLE || pulseEnd) begin
      tickIdx <= 9'h0;
    end else if (tickStrobe) begin
      tickIdx <= tickIdx + 9'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || state == SS_IDLE || (pulseEnd && state != SS_SYNC && state != SS_NIB)) begin
      frameTicks <= 9'h0;
    end else if (pulseEnd && state == SS_NIB && nibIdx == dataCount + 3'h1 && ctrl.outMode == 2'h2) begin
      frameTicks <= 9'h0;
    end else if (tickStrobe) begin
      frameTicks <= frameTicks + 9'h1;
    end
  end

  // Err bit held until a frame has carried it; set wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      errLatch <= 1'b0;
    end else if (faultDet) begin
      errLatch <= 1'b1;
    end else if (state == SS_SYNC && pulseEnd) begin
      errLatch <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state    <= SS_IDLE;
      nibIdx   <= 3'h0;
      pulseLen <= 9'(`SEO_SYNC_TICKS);
    end else begin
      case (state)
        SS_IDLE: begin
          if (sentOn) begin
            state    <= SS_SYNC;
            pulseLen <= 9'(`SEO_SYNC_TICKS);
          end
        end
        SS_SYNC: begin
          if (pulseEnd) begin
            state    <= SS_NIB;
            nibIdx   <= 3'h0;
            pulseLen <= 9'(`SEO_NIB_BASE_TICKS) + 9'({2'b00, errLatch, 1'b0});
          end
        end
        SS_NIB: begin
          if (pulseEnd) begin
            if (nibIdx == dataCount + 3'h1) begin
              if (ctrl.outMode == 2'h3) begin
                state    <= SS_PAUSE;
                pulseLen <= next_pauseLen;
              end else begin
                state    <= sentOn ? SS_SYNC : SS_IDLE;
                pulseLen <= 9'(`SEO_SYNC_TICKS);
              end
            end else begin
              nibIdx   <= nibIdx + 3'h1;
              pulseLen <= 9'(`SEO_NIB_BASE_TICKS) + 9'(nibIdx == 3'h0 ? dataNib[0] : frameNib[nibIdx + 3'h1]);
            end
          end
        end
        SS_PAUSE: begin
          if (pulseEnd) begin
            state    <= sentOn ? SS_SYNC : SS_IDLE;
            pulseLen <= 9'(`SEO_SYNC_TICKS);
          end
        end
        default: begin
          state <= SS_IDLE;
        end
      endcase
    end
  end

  // sample frame data at end of status nibble
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        frameNib[i] <= 4'h0;
      end
      lastCrc    <= 4'h0;
      frameCount <= 16'h0;
    end else if (state == SS_SYNC && pulseEnd) begin
      frameNib[0] <= {2'b00, errLatch, 1'b0};
    end else if (state == SS_NIB && pulseEnd && nibIdx == 3'h0) begin
      for (int i = 0; i < 6; i++) begin
        frameNib[i + 1] <= dataNib[i];
      end
      frameNib[dataCount + 3'h1] <= next_crc;
      lastCrc    <= next_crc;
      frameCount <= frameCount + 16'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sigOut   <= 1'b1;
      sigOutEn <= 1'b0;
    end else begin
      if (sentOn) begin
        sigOut <= (state == SS_IDLE) || (tickIdx >= 9'(`SEO_NIB_LOW_TICKS));
      end else begin
        sigOut <= pwmWave;
      end
      sigOutEn <= !ctrl.analogSel && !(fault && ctrl.outMode != 2'h0);
    end
  end

  assign apbAccess = psel && penable;
  assign apbMapped = (paddr == `SEO_OFF_CTRL) || (paddr == `SEO_OFF_STATUS) || (paddr == `SEO_OFF_VALUE);
  assign pready    = 1'b1;
  assign pslverr   = apbAccess && !apbMapped;

  // Control register, byte enables honoured
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= `SEO_CTRL_RST;
    end else if (apbAccess && pwrite && paddr == `SEO_OFF_CTRL) begin
      for (int b = 0; b < 3; b++) begin
        if (pstrb[b]) begin
          ctrl[b*8 +: 4] <= pwdata[b*8 +: 4];
          if (b < 2) begin
            ctrl[b*8 + 4 +: 4] <= pwdata[b*8 + 4 +: 4];
          end
        end
      end
    end
  end

  // Read data captured in setup phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SEO_OFF_CTRL:   prdata <= {12'h000, ctrl};
        `SEO_OFF_STATUS: prdata <= {4'h0, lastCrc, 2'b00, state, 1'b0, errLatch, faultDet, fault, frameCount};
        `SEO_OFF_VALUE:  prdata <= {4'h0, clampedValue, 4'h0, sense.pressure};
        default:         prdata <= 32'h0;
      endcase
    end
  end

endmodule

// >>> verif/seo_host_model.sv
module seo_host_model (
  input wire logic sys_clk,
  input wire logic sigOut,
  input wire logic sigOutEn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pin;
  logic prevPin = 1'b1;
  int   cnt = 0;
  int   lc = 0;
  int   hc = 0;
  int   ivl[$];
  int   lo[$];
  int   hi[$];
  // Pull-up on released line
  assign pin = sigOutEn ? sigOut : 1'b1;
  always @(posedge sys_clk) begin
    prevPin <= pin;
    cnt <= cnt + 1;
    lc <= pin ? 0 : lc + 1;
    hc <= pin ? hc + 1 : 0;
    if (prevPin && !pin) begin
      ivl.push_back(cnt);
      hi.push_back(hc);
      cnt <= 1;
    end
    if (!prevPin && pin) begin
      lo.push_back(lc);
    end
  end
endmodule

// >>> verif/seo_top_sva.sv
module seo_top_sva
  import seo_pkg::*;
#(
  parameter int unsigned PWM_CLK_HZ = 100000000
)
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        faultDet,
  input wire logic [11:0] analogLevel,
  input wire logic        analogEn,
  input wire logic        sigOut,
  input wire logic        sigOutEn
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK[8] = '{300, 500, 250, 200, 150, 100, 75, 50};
  localparam int HZ[8] = '{1000, 250, 500, 1600, 2667, 4000, 8000, 16000};
  seo_ctrl_s sh;
  logic      prevOut, rise, fall, sent, pwm;
  int        sinceWr, lowCnt, highCnt, fallCnt, riseCnt, tk, per, hiLim, loLim;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Shadow of control word
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sh <= '0;
      sinceWr <= 0;
    end else if (psel && penable && pwrite && paddr == 12'h000) begin
      sh <= seo_ctrl_s'(pwdata[19:0]);
      sinceWr <= 0;
    end else if (sinceWr < 1000000) begin
      sinceWr <= sinceWr + 1;
    end
  end
  // Edge interval counters
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prevOut <= 1'b1;
      lowCnt <= 0;
      highCnt <= 0;
      fallCnt <= 0;
      riseCnt <= 0;
    end else begin
      prevOut <= sigOut;
      lowCnt <= sigOut ? 0 : lowCnt + 1;
      highCnt <= sigOut ? highCnt + 1 : 0;
      fallCnt <= fall ? 1 : fallCnt + 1;
      riseCnt <= rise ? 1 : riseCnt + 1;
    end
  end
  assign rise = sigOut && !prevOut;
  assign fall = !sigOut && prevOut;
  assign sent = sh.outMode[1] && sigOutEn;
  assign pwm = !sh.outMode[1] && sigOutEn;
  assign tk = TK[sh.rate];
  assign per = PWM_CLK_HZ / HZ[sh.rate];
  assign hiLim = (sh.clampHi > 26 ? 70 : 96 - sh.clampHi) * 4095 / 100;
  assign loLim = (sh.clampLo > 26 ? 30 : 4 + sh.clampLo) * 4095 / 100;
  sequence sentFall;
    sent && fall && sinceWr > fallCnt + 4;
  endsequence
  sequence pwmRise;
    pwm && rise && sinceWr > riseCnt + 4;
  endsequence
  clamp_range_a: assert property (
    analogEn && sinceWr > 4 |-> analogLevel <= hiLim && analogLevel >= loLim)
    else $error("analog level outside clamps");
  analog_hiz_a: assert property (
    faultDet && sh.diagEn && sinceWr > 4 |-> ##[1:4] !analogEn)
    else $error("analog driver kept on during fault");
  pin_hiz_a: assert property (
    faultDet && sh.diagEn && sh.outMode == 2'd1 && sinceWr > 4 |-> ##[1:4] !sigOutEn)
    else $error("pin kept driven during fault");
  low_interval_a: assert property (
    sent && rise && sinceWr > lowCnt + 4 |-> lowCnt == 5 * tk)
    else $error("pulse low interval wrong");
  tick_whole_a: assert property (
    sentFall |-> fallCnt % tk == 0)
    else $error("interval not whole ticks");
  nibble_len_a: assert property (
    sentFall ##0 !sh.outMode[0] |-> fallCnt == 56 * tk || (fallCnt >= 12 * tk && fallCnt <= 27 * tk))
    else $error("interval length illegal");
  pause_min_a: assert property (
    sentFall ##0 sh.outMode[0] |-> fallCnt >= 12 * tk)
    else $error("interval shorter than twelve ticks");
  pwm_period_a: assert property (
    pwmRise |-> riseCnt == per)
    else $error("pwm period wrong");
  pwm_duty_a: assert property (
    pwm && fall && sinceWr > highCnt + 4 |-> highCnt <= (per * hiLim) >> 12 && highCnt >= (per * (loLim - 7)) >> 12)
    else $error("pwm duty outside clamps");
endmodule

bind seo_top seo_top_sva #(.PWM_CLK_HZ(PWM_CLK_HZ)) u_sva (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .faultDet(faultDet),
  .analogLevel(analogLevel), .analogEn(analogEn), .sigOut(sigOut), .sigOutEn(sigOutEn));

// >>> verif/testbench.sv
module testbench
  import seo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PCLK = 250000;
  localparam int T = 50;
  localparam int HZ[8] = '{1000, 250, 500, 1600, 2667, 4000, 8000, 16000};
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        faultDet = 1'b0;
  seo_sense_s  sense = '0;
  logic [31:0] prdata, rdq;
  logic [11:0] analogLevel;
  logic        pready, pslverr, errq, analogEn, sigOut, sigOutEn;
  int          mismatches = 0;
  int          nCompared = 0;
  int          at[7][4] = '{'{0, 0, 4095, 3931}, '{0, 0, 0, 163}, '{25, 25, 4095, 2907}, '{25, 25, 0, 1187},
                            '{31, 27, 4095, 2866}, '{31, 27, 0, 1228}, '{31, 27, 2048, 2048}};

  seo_top #(.PWM_CLK_HZ(PCLK)) u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense(sense), .faultDet(faultDet), .analogLevel(analogLevel),
    .analogEn(analogEn), .sigOut(sigOut), .sigOutEn(sigOutEn));
  seo_host_model u_host (.sys_clk(sys_clk), .sigOut(sigOut), .sigOutEn(sigOutEn));

  always #5 sys_clk = ~sys_clk;

  task automatic complete_run();
    if (mismatches == 0 && nCompared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rdq = prdata;
    errq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pstrb <= 4'h0;
  endtask

  function automatic logic [3:0] crc4(input logic [3:0] c, input logic [3:0] d);
    logic [3:0] r;
    r = c;
    for (int i = 3; i >= 0; i--)
      r = {r[2:0], d[i]} ^ (r[3] ? 4'hd : 4'h0);
    return r;
  endfunction

  task automatic pwm_rate(input int r, input logic [11:0] p, input int lvl);
    int per, n;
    per = PCLK / HZ[r];
    n = 0;
    sense.pressure <= p;
    apb(1'b1, 12'h000, 32'(r << 3));
    u_host.ivl.delete();
    u_host.hi.delete();
    while (u_host.ivl.size() < 3 && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("pwm period", per, u_host.ivl[2]);
    chk("pwm high", (per * lvl) >> 12, u_host.hi[1]);
  endtask

  task automatic sent_frame(input int cfg);
    int n, s, nn, tot;
    logic [27:0] dat;
    logic [3:0]  c, v;
    nn = cfg == 0 ? 3 : (cfg == 1 ? 5 : 6);
    apb(1'b1, 12'h000, 32'(cfg << 16 | 7 << 3 | 2 | cfg % 2) | (cfg == 1 ? 32'h4_0000 : 32'h0));
    dat = cfg == 0 ? {16'h0, sense.pressure} : (cfg == 1 ? {8'h0, sense.pressure, sense.diag} :
                                                {4'h0, sense.pressure, sense.intTemp});
    c = cfg == 1 ? crc4(4'h5, 4'h0) : 4'h5;
    u_host.ivl.delete();
    u_host.lo.delete();
    s = -1;
    n = 0;
    while (n < 40000 && !(s >= 0 && u_host.ivl.size() > s + nn + 3)) begin
      @(posedge sys_clk);
      n++;
      foreach (u_host.ivl[i])
        if (s < 0 && u_host.ivl[i] == 56 * T)
          s = i;
    end
    chk("sync found", 1, {31'h0, s >= 0});
    if (s < 0)
      return;
    chk("status nibble", 12 * T, u_host.ivl[s + 1]);
    tot = 56 + 12;
    for (int k = 0; k < nn; k++) begin
      v = dat[4 * (nn - 1 - k) +: 4];
      c = crc4(c, v);
      tot += 12 + v;
      chk("data nibble", (12 + v) * T, u_host.ivl[s + 2 + k]);
    end
    c = crc4(c, 4'h0);
    tot += 12 + c;
    chk("crc nibble", (12 + c) * T, u_host.ivl[s + 2 + nn]);
    chk("low interval", 5 * T, u_host.lo[u_host.lo.size() - 1]);
    if (cfg % 2)
      chk("frame length", (56 + (nn + 2) * 27 + 12) * T, tot * T + u_host.ivl[s + 3 + nn]);
    else
      chk("next sync", 56 * T, u_host.ivl[s + 3 + nn]);
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    chk("reset pins", 32'h4, {29'h0, sigOut, sigOutEn, analogEn});
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", 32'h0, rdq);
    chk("pready", 32'h1, {31'h0, pready});
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, errq});
    foreach (at[i]) begin
      apb(1'b1, 12'h000, 32'(at[i][1] << 11 | at[i][0] << 6 | 4));
      sense.pressure <= 12'(at[i][2]);
      repeat (8) @(posedge sys_clk);
      chk("analog level", at[i][3], {20'h0, analogLevel});
      chk("analog enable", 32'h1, {31'h0, analogEn});
    end
    for (int r = 0; r < 8; r++)
      pwm_rate(r, 12'h800, 2048);
    pwm_rate(0, 12'hfff, 3931);
    pwm_rate(0, 12'h000, 163);
    sense <= '{12'ha5c, 8'h3e, 12'h7c1};
    for (int g = 0; g < 4; g++)
      sent_frame(g);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 12'h000, m ? 32'h0008_0001 : 32'h0008_0004);
      faultDet <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk("fault analog", 32'h0, {31'h0, analogEn});
      chk("fault pin", 32'h0, {31'h0, sigOutEn});
      faultDet <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk("clear analog", 32'(m == 0), {31'h0, analogEn});
      chk("clear pin", 32'(m == 1), {31'h0, sigOutEn});
    end
    complete_run();
  end
endmodule
